/* File: common/tdic_pkg.sv */
/*
  Constants for the time-of-day and interval counter: register addresses,
  control field positions, reset values and counter limits.
  Assumes a byte-wide special-function register port and a 1/128 s tick input.
*/
// Summary of operation
// - Seconds advance once per second while enabled.
// - Seconds wrap 59 to 0, carry minutes.
// - Minutes wrap 59 to 0, carry hours.
// - 24-hour mode: hours wrap 23 to 0.
// - 24-hour bit clear: hours wrap at 255.
// - Software preloads time, counting starts on enable.
// - Disable stops clock, restores last written time.
// - Interval counter steps at selected timebase.
// - Timebase codes: tick, seconds, minutes, hours.
// - Target and interval counter are eight bits.
// - Counter equals target sets sticky match flag.
package tdic_pkg;
  localparam logic [7:0] TDIC_ADDR_CTRL   = 8'ha1;
  localparam logic [7:0] TDIC_ADDR_FRAC   = 8'ha2;
  localparam logic [7:0] TDIC_ADDR_SEC    = 8'ha3;
  localparam logic [7:0] TDIC_ADDR_MIN    = 8'ha4;
  localparam logic [7:0] TDIC_ADDR_HOUR   = 8'ha5;
  localparam logic [7:0] TDIC_ADDR_TARGET = 8'ha6;
  localparam logic [7:0] TDIC_RST_VAL     = 8'h00;
  localparam int         TDIC_BIT_TIME_EN = 0;
  localparam int         TDIC_BIT_INTV_EN = 1;
  localparam int         TDIC_BIT_MATCH   = 2;
  localparam int         TDIC_BIT_SINGLE  = 3;
  localparam int         TDIC_BIT_TS_LO   = 4;
  localparam int         TDIC_BIT_TS_HI   = 5;
  localparam int         TDIC_BIT_H24     = 6;
  localparam logic [7:0] TDIC_FRAC_MAX    = 8'h7f;
  localparam logic [7:0] TDIC_SEC_MAX     = 8'h3b;
  localparam logic [7:0] TDIC_MIN_MAX     = 8'h3b;
  localparam logic [7:0] TDIC_HOUR_MAX24  = 8'h17;
  localparam logic [7:0] TDIC_HOUR_MAXALL = 8'hff;
  localparam logic [1:0] TDIC_TB_TICK     = 2'h0;
  localparam logic [1:0] TDIC_TB_SEC      = 2'h1;
  localparam logic [1:0] TDIC_TB_MIN      = 2'h2;
  localparam logic [1:0] TDIC_TB_HOUR     = 2'h3;
  localparam logic [7:0] TDIC_ONE         = 8'h01;
endpackage : tdic_pkg

/* File: verilog/tdic_wrap_cnt.sv */
/*
  One wrapping 8-bit time digit with load, restore and carry.
  Assumes the parent supplies the step enable and the wrap limit.
*/
`timescale 1ns/1ps
module tdic_wrap_cnt
  import tdic_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Control
  input  wire logic       step,
  input  wire logic [7:0] limit,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       restore,
  // Result
  output logic      [7:0] value,
  output logic            carry
);
  logic [7:0] shadow_r;
  logic [7:0] shadow_nxt;
  logic [7:0] value_r;
  logic [7:0] value_nxt;

  assign value = value_r;
  assign carry = step && (value_r >= limit);

  always_comb
  begin
    shadow_nxt = load ? load_val : shadow_r;
    value_nxt  = value_r;
    if (load)
    begin
      value_nxt = load_val;
    end
    else if (restore)
    begin
      value_nxt = shadow_r;
    end
    else if (step)
    begin
      value_nxt = carry ? TDIC_RST_VAL : value_r + TDIC_ONE;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      shadow_r <= TDIC_RST_VAL;
      value_r  <= TDIC_RST_VAL;
    end
    else
    begin
      shadow_r <= shadow_nxt;
      value_r  <= value_nxt;
    end
  end
endmodule : tdic_wrap_cnt

/* File: verilog/tdic_top.sv */
/*
  Time-of-day and interval counter with byte-wide register port.
  Assumes a one-cycle tick input every 1/128 s and single-cycle register strobes.
*/
`timescale 1ns/1ps
module tdic_top
  import tdic_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Timebase
  input  wire logic       tick_128,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Status
  output logic            interval_match_flag
);
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] intv_r;
  logic [7:0] intv_nxt;
  logic [7:0] target_r;
  logic [7:0] target_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] frac_v;
  logic [7:0] sec_v;
  logic [7:0] min_v;
  logic [7:0] hour_v;
  logic       frac_c;
  logic       sec_c;
  logic       min_c;
  logic       time_clock_enable;
  logic       interval_count_enable;
  logic       restore;
  logic       unit_step;
  logic [1:0] tb_sel;
  logic       ld_ctrl;
  logic       ld_frac;
  logic       ld_sec;
  logic       ld_min;
  logic       ld_hour;
  logic       ld_target;
  logic       intv_run;
  logic       intv_match;
  logic [7:0] intv_inc;

  // Strobe and address come in as arguments so that every use follows their changes.
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] a);
    wr_hit = wr && (addr == a);
  endfunction : wr_hit

  assign ld_ctrl               = wr_hit(reg_wr, reg_addr, TDIC_ADDR_CTRL);
  assign ld_frac               = wr_hit(reg_wr, reg_addr, TDIC_ADDR_FRAC);
  assign ld_sec                = wr_hit(reg_wr, reg_addr, TDIC_ADDR_SEC);
  assign ld_min                = wr_hit(reg_wr, reg_addr, TDIC_ADDR_MIN);
  assign ld_hour               = wr_hit(reg_wr, reg_addr, TDIC_ADDR_HOUR);
  assign ld_target             = wr_hit(reg_wr, reg_addr, TDIC_ADDR_TARGET);
  assign time_clock_enable     = ctrl_r[TDIC_BIT_TIME_EN];
  assign interval_count_enable = ctrl_r[TDIC_BIT_INTV_EN];
  assign interval_match_flag   = ctrl_r[TDIC_BIT_MATCH];
  assign tb_sel                = {ctrl_r[TDIC_BIT_TS_HI], ctrl_r[TDIC_BIT_TS_LO]};
  assign reg_rdata             = rdata_r;
  // Restore happens on the falling edge of the enable bit written by software.
  assign restore               = ld_ctrl && time_clock_enable && !reg_wdata[TDIC_BIT_TIME_EN];
  // A software write that drops the interval enable wins over a count in the same cycle.
  assign intv_run              = ld_ctrl ? reg_wdata[TDIC_BIT_INTV_EN] : interval_count_enable;
  assign intv_inc              = intv_r + TDIC_ONE;
  assign intv_match            = intv_run && interval_count_enable && unit_step && (intv_inc == target_r);

  tdic_wrap_cnt u_frac (
    .clock    (clock),
    .srst     (srst),
    .step     (time_clock_enable && tick_128),
    .limit    (TDIC_FRAC_MAX),
    .load     (ld_frac),
    .load_val (reg_wdata),
    .restore  (restore),
    .value    (frac_v),
    .carry    (frac_c)
  );
  tdic_wrap_cnt u_sec (
    .clock    (clock),
    .srst     (srst),
    .step     (frac_c),
    .limit    (TDIC_SEC_MAX),
    .load     (ld_sec),
    .load_val (reg_wdata),
    .restore  (restore),
    .value    (sec_v),
    .carry    (sec_c)
  );
  tdic_wrap_cnt u_min (
    .clock    (clock),
    .srst     (srst),
    .step     (sec_c),
    .limit    (TDIC_MIN_MAX),
    .load     (ld_min),
    .load_val (reg_wdata),
    .restore  (restore),
    .value    (min_v),
    .carry    (min_c)
  );
  tdic_wrap_cnt u_hour (
    .clock    (clock),
    .srst     (srst),
    .step     (min_c),
    .limit    (ctrl_r[TDIC_BIT_H24] ? TDIC_HOUR_MAX24 : TDIC_HOUR_MAXALL),
    .load     (ld_hour),
    .load_val (reg_wdata),
    .restore  (restore),
    .value    (hour_v),
    .carry    ()
  );

  always_comb
  begin
    case (tb_sel)
      TDIC_TB_TICK: unit_step = time_clock_enable && tick_128;
      TDIC_TB_SEC:  unit_step = frac_c;
      TDIC_TB_MIN:  unit_step = sec_c;
      TDIC_TB_HOUR: unit_step = min_c;
      default:      unit_step = 1'b0;
    endcase
  end

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (ld_ctrl)
    begin
      ctrl_nxt = reg_wdata;
      // The match flag is only cleared by software; writing one does not set it.
      ctrl_nxt[TDIC_BIT_MATCH] = ctrl_r[TDIC_BIT_MATCH] && reg_wdata[TDIC_BIT_MATCH];
    end
    if (intv_match)
    begin
      // Set wins over a simultaneous software clear.
      ctrl_nxt[TDIC_BIT_MATCH] = 1'b1;
      if (ctrl_r[TDIC_BIT_SINGLE])
      begin
        ctrl_nxt[TDIC_BIT_INTV_EN] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctrl_r <= TDIC_RST_VAL;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_comb
  begin
    target_nxt = target_r;
    if (ld_target)
    begin
      target_nxt = reg_wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      target_r <= TDIC_RST_VAL;
    end
    else
    begin
      target_r <= target_nxt;
    end
  end

  always_comb
  begin
    intv_nxt = intv_r;
    if (!intv_run)
    begin
      intv_nxt = TDIC_RST_VAL;
    end
    else if (interval_count_enable && unit_step)
    begin
      intv_nxt = intv_match ? TDIC_RST_VAL : intv_inc;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      intv_r <= TDIC_RST_VAL;
    end
    else
    begin
      intv_r <= intv_nxt;
    end
  end

  always_comb
  begin
    case (reg_addr)
      TDIC_ADDR_CTRL:   rdata_nxt = ctrl_r;
      TDIC_ADDR_FRAC:   rdata_nxt = frac_v;
      TDIC_ADDR_SEC:    rdata_nxt = sec_v;
      TDIC_ADDR_MIN:    rdata_nxt = min_v;
      TDIC_ADDR_HOUR:   rdata_nxt = hour_v;
      TDIC_ADDR_TARGET: rdata_nxt = target_r;
      default:          rdata_nxt = TDIC_RST_VAL;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rdata_r <= TDIC_RST_VAL;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end
endmodule : tdic_top

/* File: testbench/tdic_chk.sv */
/* Port checker for tdic_top.
   Assumes single-cycle tick and write strobes. */
`timescale 1ns/1ps
module tdic_chk
  import tdic_pkg::*;
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       srst,
  // Stimulus
  input wire logic       tick_128,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  // Results
  input wire logic [7:0] reg_rdata,
  input wire logic       interval_match_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_quiet;
    (!tick_128 && !reg_wr && $stable(reg_addr))[*3];
  endsequence
  sequence s_sec_wr;
    reg_wr && reg_addr == 8'ha3 && !tick_128 ##1 reg_addr == 8'ha3 && !reg_wr && !tick_128;
  endsequence
  a_reset_clears: assert property (disable iff (1'b0) srst |=> !interval_match_flag && reg_rdata == 8'h00)
    else $error("reset left state");
  a_flag_sticky: assert property (interval_match_flag && !(reg_wr && reg_addr == 8'ha1) |=> interval_match_flag)
    else $error("flag dropped");
  a_flag_cause: assert property ($rose(interval_match_flag) |-> $past(tick_128) || $past(tick_128, 2))
    else $error("flag without tick");
  a_unmapped_zero: assert property (!(reg_addr inside {[8'ha1:8'ha6]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  a_sec_range: assert property ($past(reg_addr) == 8'ha3 |-> reg_rdata <= TDIC_SEC_MAX)
    else $error("seconds range");
  a_min_range: assert property ($past(reg_addr) == 8'ha4 |-> reg_rdata <= TDIC_MIN_MAX)
    else $error("minutes range");
  a_quiet_hold: assert property (s_quiet |=> $stable(reg_rdata))
    else $error("change without cause");
  a_sec_load: assert property (s_sec_wr |=> reg_rdata == $past(reg_wdata, 2))
    else $error("seconds load");
endmodule : tdic_chk
bind tdic_top tdic_chk tdic_chk_i (.clock, .srst, .tick_128, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
  .interval_match_flag);

/* File: testbench/tdic_top_tb_top.sv */
/* Self-checking bench for tdic_top.
   Assumes a 50 ns clock; ticks are spaced two cycles apart. */
`timescale 1ns/1ps
module tdic_top_tb_top
  import tdic_pkg::*;
;
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic       tick_128 = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic       reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic       interval_match_flag;
  int         errors = 0;
  int         compares = 0;
  int         cyc = 0;
  always #25 clock = ~clock;
  tdic_top tdic_top_i (.clock, .srst, .tick_128, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .interval_match_flag);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_addr = a;
    @(negedge clock);
    chk(reg_rdata, exp);
  endtask : rd
  task automatic tk(input int n);
    repeat (n)
    begin
      @(negedge clock) tick_128 = 1'b1;
      @(negedge clock) tick_128 = 1'b0;
    end
  endtask : tk
  task automatic t_reset;
    for (int a = 'ha0; a < 'ha8; a++)
      rd(a[7:0], 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_time;
    wr(8'ha1, 8'h40);
    wr(8'ha3, 8'h3b);
    wr(8'ha4, 8'h3b);
    wr(8'ha5, 8'h17);
    wr(8'ha1, 8'h41);
    tk(127);
    rd(8'ha3, 8'h3b);
    tk(1);
    rd(8'ha3, 8'h00);
    rd(8'ha4, 8'h00);
    rd(8'ha5, 8'h00);
    wr(8'ha1, 8'h40);
    rd(8'ha3, 8'h3b);
    tk(128);
    rd(8'ha3, 8'h3b);
    wr(8'ha1, 8'h00);
    wr(8'ha1, 8'h01);
    tk(128);
    rd(8'ha5, 8'h18);
    $display("time test done");
  endtask : t_time
  task automatic t_ival;
    wr(8'ha1, 8'hd0);
    wr(8'ha6, 8'h14);
    wr(8'ha1, 8'hd3);
    tk(2559);
    chk({7'h00, interval_match_flag}, 8'h00);
    tk(1);
    chk({7'h00, interval_match_flag}, 8'h01);
    tk(5);
    chk({7'h00, interval_match_flag}, 8'h01);
    wr(8'ha1, 8'hd3);
    chk({7'h00, interval_match_flag}, 8'h00);
    $display("interval test done");
  endtask : t_ival
  task automatic t_once;
    wr(8'ha1, 8'hc8);
    wr(8'ha6, 8'h03);
    wr(8'ha1, 8'hcb);
    tk(2);
    chk({7'h00, interval_match_flag}, 8'h00);
    tk(1);
    rd(8'ha1, 8'hcd);
    $display("single test done");
  endtask : t_once
  task automatic t_units;
    wr(8'ha1, 8'ha0);
    wr(8'ha2, 8'h7f);
    wr(8'ha6, 8'h01);
    wr(8'ha1, 8'ha3);
    tk(1);
    chk({7'h00, interval_match_flag}, 8'h01);
    wr(8'ha1, 8'hb0);
    chk({7'h00, interval_match_flag}, 8'h00);
    wr(8'ha1, 8'hb3);
    tk(1);
    chk({7'h00, interval_match_flag}, 8'h01);
    wr(8'ha1, 8'h80);
    wr(8'ha6, 8'h00);
    wr(8'ha1, 8'h83);
    tk(255);
    chk({7'h00, interval_match_flag}, 8'h00);
    tk(1);
    chk({7'h00, interval_match_flag}, 8'h01);
    $display("units test done");
  endtask : t_units
  task automatic end_sim;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  // Ceiling sits well above the roughly 6400 cycles of tick traffic.
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      errors++;
      end_sim();
    end
  end
  initial
  begin
    repeat (4) @(negedge clock);
    srst = 1'b0;
    t_reset();
    t_time();
    t_ival();
    t_once();
    t_units();
    end_sim();
  end
endmodule : tdic_top_tb_top
